// File: mmn_core.sv
`timescale 1ns/10ps
// Behaviour
// - Store copies accumulator into addressed register; accumulator and flags unchanged.
// - The 8-bit operand reaches any location of one 256-byte bank.
// - Bank-select zero uses the fixed window; one uses the bank pointer's bank.
// - Bank pointer selection is the default meaning of bank-select set to one.
// - Extended set, bank-select zero, operand up to 95: indexed offset addressing.
// - Multiply immediate forms unsigned 16-bit product of accumulator and literal.
// - Product high byte and low byte take the halves; accumulator kept.
// - Multiply register forms unsigned product with the addressed register; sources kept.
// - Multiplies change no status flag, not even zero.
// - Negate writes the two's complement of the register back to it.
// - Negate updates negative, signed wrap, carry, half carry and zero flags.
// - Upper four bits of the bank pointer always read as zero.
// - Register operands reach a 4096-byte data space, 000h to FFFh.
module mmn_core (
    input  logic        sys_clk,
    input  logic        rst_n,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic        hresp,
    output logic [31:0] hrdata,
    output logic        exec_busy
);
    logic [7:0]          mem [0:4095];
    logic                ext_ff,      nxt_ext;
    logic [15:0]         instr_ff,    nxt_instr;
    logic [4:0]          flags_ff,    nxt_flags;
    logic [7:0]          acc_ff,      nxt_acc;
    logic [3:0]          bank_ff,     nxt_bank;
    logic [7:0]          prod_hi_ff,  nxt_prod_hi;
    logic [7:0]          prod_lo_ff,  nxt_prod_lo;
    logic [11:0]         index_ff,    nxt_index;
    logic [11:0]         maddr_ff,    nxt_maddr;
    mmn_pkg::mmn_state_t state_ff,    nxt_state;
    mmn_pkg::mmn_op_t    op_ff,       nxt_op;
    logic [11:0]         eaddr_ff,    nxt_eaddr;
    logic [7:0]          opnd_ff,     nxt_opnd;
    logic [7:0]          res_ff,      nxt_res;
    logic [4:0]          rflags_ff,   nxt_rflags;
    logic [15:0]         rprod_ff,    nxt_rprod;
    logic                wr_pend_ff,  nxt_wr_pend;
    logic                rd_pend_ff,  nxt_rd_pend;
    logic [7:0]          ba_ff,       nxt_ba;
    logic [31:0]         hrdata_ff,   nxt_hrdata;
    logic                hready_ff,   nxt_hready;
    logic                busy_ff,     nxt_busy;
    logic                hresp_ff;
    logic                take;
    logic                bus_wr;
    logic                mem_we;
    logic [11:0]         mem_wa;
    logic [7:0]          mem_wd;

    mmn_exec_if xif ();

    mmn_exec_unit u_exec (
        .xif (xif)
    );

    assign xif.op       = op_ff;
    assign xif.acc      = acc_ff;
    assign xif.opnd     = opnd_ff;
    assign xif.flags_in = flags_ff;

    assign hreadyout = hready_ff;
    assign hresp     = hresp_ff;
    assign hrdata    = hrdata_ff;
    assign exec_busy = busy_ff;

    function automatic mmn_pkg::mmn_op_t decode_word(input logic [15:0] w);
        if (w == mmn_pkg::OPC_IDLE_ZERO || w[15:12] == mmn_pkg::OPC_IDLE_HI) return mmn_pkg::OP_IDLE;
        else if (w[15:9] == mmn_pkg::OPC_STORE) return mmn_pkg::OP_STORE;
        else if (w[15:9] == mmn_pkg::OPC_NEG) return mmn_pkg::OP_NEG;
        else if (w[15:9] == mmn_pkg::OPC_MULR) return mmn_pkg::OP_MULR;
        else if (w[15:8] == mmn_pkg::OPC_MULI) return mmn_pkg::OP_MULI;
        else return mmn_pkg::OP_UNDEF;
    endfunction

    function automatic logic [11:0] resolve_addr(input logic [15:0] w, input logic ext,
                                                 input logic [3:0] bank, input logic [11:0] ibase);
        logic [7:0] f;
        f = w[7:0];
        if (w[8]) return {bank, f};
        else if (ext && f <= mmn_pkg::INDEX_LIMIT) return 12'(ibase + {4'h0, f});
        else if (f <= mmn_pkg::INDEX_LIMIT) return {mmn_pkg::WINDOW_LO_BANK, f};
        else return {mmn_pkg::WINDOW_HI_BANK, f};
    endfunction

    // Bus interface
    assign take   = hsel && htrans[1] && hready;
    assign bus_wr = wr_pend_ff && state_ff == mmn_pkg::ST_IDLE;

    always_comb begin
        nxt_wr_pend = take && hwrite && hsize == mmn_pkg::HSIZE_WORD;
        nxt_rd_pend = take && !hwrite;
        nxt_ba      = take ? haddr[7:0] : ba_ff;
        nxt_hready  = !(take && !hwrite);
        nxt_hrdata  = hrdata_ff;
        if (rd_pend_ff) begin
            if (ba_ff == mmn_pkg::OFS_CTRL) nxt_hrdata = {31'h0, ext_ff};
            else if (ba_ff == mmn_pkg::OFS_INSTR) nxt_hrdata = {16'h0, instr_ff};
            else if (ba_ff == mmn_pkg::OFS_FLAGS) nxt_hrdata = {27'h0, flags_ff};
            else if (ba_ff == mmn_pkg::OFS_ACC) nxt_hrdata = {24'h0, acc_ff};
            else if (ba_ff == mmn_pkg::OFS_BANK) nxt_hrdata = {28'h0, bank_ff};
            else if (ba_ff == mmn_pkg::OFS_PROD_HI) nxt_hrdata = {24'h0, prod_hi_ff};
            else if (ba_ff == mmn_pkg::OFS_PROD_LO) nxt_hrdata = {24'h0, prod_lo_ff};
            else if (ba_ff == mmn_pkg::OFS_INDEX) nxt_hrdata = {20'h0, index_ff};
            else if (ba_ff == mmn_pkg::OFS_MEM_ADDR) nxt_hrdata = {20'h0, maddr_ff};
            else if (ba_ff == mmn_pkg::OFS_MEM_DATA) nxt_hrdata = {24'h0, mem[maddr_ff]};
            else if (ba_ff == mmn_pkg::OFS_EXEC) nxt_hrdata = {26'h0, op_ff, state_ff};
            else nxt_hrdata = mmn_pkg::RST_WORD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            ba_ff      <= mmn_pkg::RST_BYTE;
            hready_ff  <= 1'b1;
            hrdata_ff  <= mmn_pkg::RST_WORD;
            hresp_ff   <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            rd_pend_ff <= nxt_rd_pend;
            ba_ff      <= nxt_ba;
            hready_ff  <= nxt_hready;
            hrdata_ff  <= nxt_hrdata;
            hresp_ff   <= 1'b0;
        end
    end

    // Quarter sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_op     = op_ff;
        nxt_eaddr  = eaddr_ff;
        nxt_opnd   = opnd_ff;
        nxt_res    = res_ff;
        nxt_rflags = rflags_ff;
        nxt_rprod  = rprod_ff;
        case (state_ff)
            mmn_pkg::ST_IDLE: begin
                if (bus_wr && ba_ff == mmn_pkg::OFS_INSTR) begin
                    nxt_state = mmn_pkg::ST_DECODE;
                end
            end
            mmn_pkg::ST_DECODE: begin
                nxt_op    = decode_word(instr_ff);
                nxt_eaddr = resolve_addr(instr_ff, ext_ff, bank_ff, index_ff);
                nxt_state = mmn_pkg::ST_READ;
            end
            mmn_pkg::ST_READ: begin
                nxt_opnd  = (op_ff == mmn_pkg::OP_MULI) ? instr_ff[7:0] : mem[eaddr_ff];
                nxt_state = mmn_pkg::ST_PROC;
            end
            mmn_pkg::ST_PROC: begin
                nxt_res    = xif.result;
                nxt_rflags = xif.flags_out;
                nxt_rprod  = xif.prod;
                nxt_state  = mmn_pkg::ST_WRITE;
            end
            mmn_pkg::ST_WRITE: begin
                nxt_state = mmn_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = mmn_pkg::ST_IDLE;
            end
        endcase
        nxt_busy = nxt_state != mmn_pkg::ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_ff  <= mmn_pkg::ST_IDLE;
            op_ff     <= mmn_pkg::OP_IDLE;
            eaddr_ff  <= mmn_pkg::RST_ADDR;
            opnd_ff   <= mmn_pkg::RST_BYTE;
            res_ff    <= mmn_pkg::RST_BYTE;
            rflags_ff <= mmn_pkg::RST_FLAGS;
            rprod_ff  <= mmn_pkg::RST_INSTR;
            busy_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            op_ff     <= nxt_op;
            eaddr_ff  <= nxt_eaddr;
            opnd_ff   <= nxt_opnd;
            res_ff    <= nxt_res;
            rflags_ff <= nxt_rflags;
            rprod_ff  <= nxt_rprod;
            busy_ff   <= nxt_busy;
        end
    end

    // Architectural registers
    always_comb begin
        nxt_ext     = ext_ff;
        nxt_instr   = instr_ff;
        nxt_flags   = flags_ff;
        nxt_acc     = acc_ff;
        nxt_bank    = bank_ff;
        nxt_prod_hi = prod_hi_ff;
        nxt_prod_lo = prod_lo_ff;
        nxt_index   = index_ff;
        nxt_maddr   = maddr_ff;
        if (bus_wr) begin
            if (ba_ff == mmn_pkg::OFS_CTRL) nxt_ext = hwdata[mmn_pkg::CTRL_EXT_BIT];
            else if (ba_ff == mmn_pkg::OFS_INSTR) nxt_instr = hwdata[15:0];
            else if (ba_ff == mmn_pkg::OFS_FLAGS) nxt_flags = hwdata[4:0];
            else if (ba_ff == mmn_pkg::OFS_ACC) nxt_acc = hwdata[7:0];
            else if (ba_ff == mmn_pkg::OFS_BANK) nxt_bank = hwdata[3:0];
            else if (ba_ff == mmn_pkg::OFS_PROD_HI) nxt_prod_hi = hwdata[7:0];
            else if (ba_ff == mmn_pkg::OFS_PROD_LO) nxt_prod_lo = hwdata[7:0];
            else if (ba_ff == mmn_pkg::OFS_INDEX) nxt_index = hwdata[11:0];
            else if (ba_ff == mmn_pkg::OFS_MEM_ADDR) nxt_maddr = hwdata[11:0];
        end
        if (state_ff == mmn_pkg::ST_WRITE) begin
            if (op_ff == mmn_pkg::OP_MULI || op_ff == mmn_pkg::OP_MULR) begin
                nxt_prod_hi = rprod_ff[15:8];
                nxt_prod_lo = rprod_ff[7:0];
            end else if (op_ff == mmn_pkg::OP_NEG) begin
                nxt_flags = rflags_ff;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_ff     <= 1'b0;
            instr_ff   <= mmn_pkg::RST_INSTR;
            flags_ff   <= mmn_pkg::RST_FLAGS;
            acc_ff     <= mmn_pkg::RST_BYTE;
            bank_ff    <= mmn_pkg::RST_BANK;
            prod_hi_ff <= mmn_pkg::RST_BYTE;
            prod_lo_ff <= mmn_pkg::RST_BYTE;
            index_ff   <= mmn_pkg::RST_ADDR;
            maddr_ff   <= mmn_pkg::RST_ADDR;
        end else begin
            ext_ff     <= nxt_ext;
            instr_ff   <= nxt_instr;
            flags_ff   <= nxt_flags;
            acc_ff     <= nxt_acc;
            bank_ff    <= nxt_bank;
            prod_hi_ff <= nxt_prod_hi;
            prod_lo_ff <= nxt_prod_lo;
            index_ff   <= nxt_index;
            maddr_ff   <= nxt_maddr;
        end
    end

    // Data space write port
    always_comb begin
        mem_we = 1'b0;
        mem_wa = maddr_ff;
        mem_wd = hwdata[7:0];
        if (state_ff == mmn_pkg::ST_WRITE && (op_ff == mmn_pkg::OP_STORE || op_ff == mmn_pkg::OP_NEG)) begin
            mem_we = 1'b1;
            mem_wa = eaddr_ff;
            mem_wd = res_ff;
        end else if (bus_wr && ba_ff == mmn_pkg::OFS_MEM_DATA) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_quarters;
        state_ff == mmn_pkg::ST_DECODE |=> state_ff == mmn_pkg::ST_READ ##1 state_ff == mmn_pkg::ST_PROC
            ##1 state_ff == mmn_pkg::ST_WRITE ##1 state_ff == mmn_pkg::ST_IDLE;
    endproperty
    a_quarters: assert property (p_quarters) else $error("quarter sequence broken");
    property p_store;
        state_ff == mmn_pkg::ST_WRITE && op_ff == mmn_pkg::OP_STORE |=>
            mem[$past(eaddr_ff)] == acc_ff && $stable(acc_ff) && $stable(flags_ff);
    endproperty
    a_store: assert property (p_store) else $error("store result wrong");
    property p_mul_prod;
        state_ff == mmn_pkg::ST_PROC && (op_ff == mmn_pkg::OP_MULI || op_ff == mmn_pkg::OP_MULR) |=>
            ##1 {prod_hi_ff, prod_lo_ff} == 16'($past(acc_ff, 2)) * 16'($past(opnd_ff, 2));
    endproperty
    a_mul_prod: assert property (p_mul_prod) else $error("product wrong");
    property p_mul_keep;
        state_ff == mmn_pkg::ST_WRITE && (op_ff == mmn_pkg::OP_MULI || op_ff == mmn_pkg::OP_MULR) |=>
            $stable(flags_ff) && $stable(acc_ff);
    endproperty
    a_mul_keep: assert property (p_mul_keep) else $error("multiply touched flags");

    property p_neg;
        state_ff == mmn_pkg::ST_WRITE && op_ff == mmn_pkg::OP_NEG |=>
            mem[$past(eaddr_ff)] == 8'(8'h00 - $past(opnd_ff));
    endproperty
    a_neg: assert property (p_neg) else $error("negate result wrong");

    property p_neg_zero;
        state_ff == mmn_pkg::ST_PROC && op_ff == mmn_pkg::OP_NEG && opnd_ff == 8'h00 |=>
            ##1 flags_ff[mmn_pkg::FLG_Z] && flags_ff[mmn_pkg::FLG_C] && !flags_ff[mmn_pkg::FLG_N];
    endproperty
    a_neg_zero: assert property (p_neg_zero) else $error("negate flags wrong");

    property p_bank_read;
        rd_pend_ff && ba_ff == mmn_pkg::OFS_BANK |=> hrdata_ff[31:4] == 28'h0 && hready_ff;
    endproperty
    a_bank_read: assert property (p_bank_read) else $error("bank pointer high bits");

    property p_bank_sel;
        state_ff == mmn_pkg::ST_READ && instr_ff[8] |-> eaddr_ff == {bank_ff, instr_ff[7:0]};
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank select wrong");

    property p_indexed;
        state_ff == mmn_pkg::ST_READ && !instr_ff[8] && ext_ff && instr_ff[7:0] <= mmn_pkg::INDEX_LIMIT |->
            eaddr_ff == 12'(index_ff + {4'h0, instr_ff[7:0]});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_idle;
        state_ff == mmn_pkg::ST_WRITE && op_ff == mmn_pkg::OP_IDLE |=>
            $stable(acc_ff) && $stable(flags_ff) && $stable(prod_hi_ff) && $stable(prod_lo_ff);
    endproperty
    a_idle: assert property (p_idle) else $error("idle changed state");
endmodule

// File: mmn_exec_if.sv
`timescale 1ns/10ps
interface mmn_exec_if;
    mmn_pkg::mmn_op_t op;
    logic [7:0]       acc;
    logic [7:0]       opnd;
    logic [4:0]       flags_in;
    logic [7:0]       result;
    logic [15:0]      prod;
    logic [4:0]       flags_out;

    modport core (output op, acc, opnd, flags_in, input result, prod, flags_out);
    modport unit (input op, acc, opnd, flags_in, output result, prod, flags_out);
endinterface

// File: mmn_exec_unit.sv
`timescale 1ns/10ps
module mmn_exec_unit (
    mmn_exec_if.unit xif
);
    logic [7:0] neg_val;

    always_comb begin
        neg_val       = 8'(~xif.opnd + 8'h01);
        xif.prod      = 16'(xif.acc) * 16'(xif.opnd);
        xif.result    = xif.opnd;
        xif.flags_out = xif.flags_in;
        case (xif.op)
            mmn_pkg::OP_STORE: begin
                xif.result = xif.acc;
            end
            mmn_pkg::OP_NEG: begin
                xif.result                     = neg_val;
                xif.flags_out[mmn_pkg::FLG_N]  = neg_val[7];
                xif.flags_out[mmn_pkg::FLG_OV] = (xif.opnd == 8'h80);
                xif.flags_out[mmn_pkg::FLG_C]  = (xif.opnd == 8'h00);
                xif.flags_out[mmn_pkg::FLG_DC] = (xif.opnd[3:0] == 4'h0);
                xif.flags_out[mmn_pkg::FLG_Z]  = (neg_val == 8'h00);
            end
            default: begin
            end
        endcase
    end
endmodule

// File: mmn_pkg.sv
package mmn_pkg;
    // Register offsets (byte addresses on the bus)
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_INSTR      = 8'h04;
    localparam logic [7:0]  OFS_FLAGS      = 8'h08;
    localparam logic [7:0]  OFS_ACC        = 8'h0c;
    localparam logic [7:0]  OFS_BANK       = 8'h10;
    localparam logic [7:0]  OFS_PROD_HI    = 8'h14;
    localparam logic [7:0]  OFS_PROD_LO    = 8'h18;
    localparam logic [7:0]  OFS_INDEX      = 8'h1c;
    localparam logic [7:0]  OFS_MEM_ADDR   = 8'h20;
    localparam logic [7:0]  OFS_MEM_DATA   = 8'h24;
    localparam logic [7:0]  OFS_EXEC       = 8'h28;

    // Field positions
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          FLG_C          = 0;
    localparam int          FLG_DC         = 1;
    localparam int          FLG_Z          = 2;
    localparam int          FLG_OV         = 3;
    localparam int          FLG_N          = 4;

    // Values after reset
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_INSTR      = 16'h0000;
    localparam logic [11:0] RST_ADDR       = 12'h000;
    localparam logic [4:0]  RST_FLAGS      = 5'h00;
    localparam logic [3:0]  RST_BANK       = 4'h0;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;

    // Opcode patterns
    localparam logic [6:0]  OPC_STORE      = 7'h37;
    localparam logic [6:0]  OPC_NEG        = 7'h36;
    localparam logic [6:0]  OPC_MULR       = 7'h01;
    localparam logic [7:0]  OPC_MULI       = 8'h0d;
    localparam logic [3:0]  OPC_IDLE_HI    = 4'hf;
    localparam logic [15:0] OPC_IDLE_ZERO  = 16'h0000;

    // Fixed window layout
    localparam logic [7:0]  INDEX_LIMIT    = 8'h5f;
    localparam logic [3:0]  WINDOW_LO_BANK = 4'h0;
    localparam logic [3:0]  WINDOW_HI_BANK = 4'hf;

    localparam logic [2:0]  HSIZE_WORD     = 3'b010;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DECODE = 3'b001,
        ST_READ   = 3'b010,
        ST_PROC   = 3'b011,
        ST_WRITE  = 3'b100
    } mmn_state_t;

    typedef enum logic [2:0] {
        OP_IDLE  = 3'b000,
        OP_STORE = 3'b001,
        OP_MULI  = 3'b010,
        OP_MULR  = 3'b011,
        OP_NEG   = 3'b100,
        OP_UNDEF = 3'b101
    } mmn_op_t;
endpackage

// File: move_multiply_negate_exec_tb_top.sv
`timescale 1ns/10ps
module move_multiply_negate_exec_tb_top;
    logic        sys_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        exec_busy;
    int          fail_count;
    int          check_count;
    logic [31:0] rng;
    logic [31:0] d;
    logic [15:0] w;
    logic [7:0]  fv;
    logic [7:0]  kv;
    logic [7:0]  opnd;
    logic        av;
    int          m_acc;
    int          m_flg;
    int          m_ph;
    int          m_pl;
    int          m_bank;
    int          m_ext;
    int          m_idx;
    int          m_mem;
    int          addr;
    int          r;

    mmn_core u_dut (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hsize    (hsize),
        .hwdata   (hwdata),
        .hready   (hreadyout),
        .hreadyout(hreadyout),
        .hresp    (hresp),
        .hrdata   (hrdata),
        .exec_busy(exec_busy)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic int resolve(input int a, input int f);
        if (a != 0) return m_bank * 256 + f;
        if (m_ext != 0 && f <= 95) return (m_idx + f) % 4096;
        return (f <= 95) ? f : 32'hf00 + f;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) cmp(32'h1, 32'h0, "bus hang");
    endtask

    task automatic addr_ph(input logic [7:0] ofs, input logic wr);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= mmn_pkg::HSIZE_WORD;
        wait_ready();
        htrans <= 2'b00;
    endtask

    task automatic bus_wr(input logic [7:0] ofs, input logic [31:0] v);
        addr_ph(ofs, 1'b1);
        hwdata <= v;
        wait_ready();
    endtask

    task automatic bus_rd(input logic [7:0] ofs, output logic [31:0] v);
        addr_ph(ofs, 1'b0);
        wait_ready();
        v = hrdata;
        cmp({31'h0, hresp}, 32'h0, "hresp");
    endtask

    task automatic run_instr(input logic [15:0] word);
        int n;
        bus_wr(mmn_pkg::OFS_INSTR, {16'h0, word});
        #1;
        n = 0;
        while (exec_busy === 1'b1 && n < 16) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmp(n, 4, "busy cycles");
    endtask

    task automatic check_state();
        bus_rd(mmn_pkg::OFS_ACC, d);
        cmp(d, m_acc, "acc");
        bus_rd(mmn_pkg::OFS_FLAGS, d);
        cmp(d, m_flg, "flags");
        bus_rd(mmn_pkg::OFS_PROD_HI, d);
        cmp(d, m_ph, "prod high");
        bus_rd(mmn_pkg::OFS_PROD_LO, d);
        cmp(d, m_pl, "prod low");
        bus_wr(mmn_pkg::OFS_MEM_ADDR, addr);
        bus_rd(mmn_pkg::OFS_MEM_DATA, d);
        cmp(d, m_mem, "data");
    endtask

    task automatic complete_run();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        rng = 32'h46fc00ba;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fail_count = 0;
        check_count = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            bus_rd(8'(i * 4), d);
            if (i != 9) cmp(d, 32'h0, "reset value");
        end
        bus_rd(8'h40, d);
        cmp(d, 32'h0, "unmapped");
        bus_wr(mmn_pkg::OFS_BANK, 32'hab);
        bus_rd(mmn_pkg::OFS_BANK, d);
        cmp(d, 32'h0b, "bank");
        for (int i = 0; i < 50; i++) begin
            av = 1'(rnd());
            fv = (i % 3 == 0) ? ((i % 2 == 1) ? 8'h5f : 8'h60) : 8'(rnd());
            kv = (i < 5) ? 8'h00 : 8'(rnd());
            m_ext = rnd() & 1;
            m_acc = rnd() & 8'hff;
            m_flg = (i < 5) ? 0 : rnd() & 5'h1f;
            r = rnd() & 8'hff;
            m_bank = r & 4'hf;
            m_idx = rnd() & 12'hfff;
            m_ph = rnd() & 8'hff;
            m_pl = rnd() & 8'hff;
            opnd = (i < 20) ? {i % 10 == 3, 2'b00, i[2:0] == 3'd3, 4'h0} : 8'(rnd());
            addr = resolve(av, fv);
            m_mem = opnd;
            bus_wr(mmn_pkg::OFS_CTRL, m_ext);
            bus_wr(mmn_pkg::OFS_ACC, m_acc);
            bus_wr(mmn_pkg::OFS_FLAGS, m_flg);
            bus_wr(mmn_pkg::OFS_BANK, r);
            bus_wr(mmn_pkg::OFS_INDEX, m_idx);
            bus_wr(mmn_pkg::OFS_PROD_HI, m_ph);
            bus_wr(mmn_pkg::OFS_PROD_LO, m_pl);
            bus_wr(mmn_pkg::OFS_MEM_ADDR, addr);
            bus_wr(mmn_pkg::OFS_MEM_DATA, opnd);
            case (i % 5)
                0: begin
                    w = {mmn_pkg::OPC_STORE, av, fv};
                    m_mem = m_acc;
                end
                1: begin
                    w = {mmn_pkg::OPC_MULI, kv};
                    m_ph = (m_acc * kv) >> 8;
                    m_pl = (m_acc * kv) & 8'hff;
                end
                2: begin
                    w = {mmn_pkg::OPC_MULR, av, fv};
                    m_ph = (m_acc * opnd) >> 8;
                    m_pl = (m_acc * opnd) & 8'hff;
                end
                3: begin
                    w = {mmn_pkg::OPC_NEG, av, fv};
                    m_mem = (256 - opnd) & 8'hff;
                    m_flg = ((m_mem >> 7) << mmn_pkg::FLG_N) | ((opnd == 8'h80) ? 8 : 0)
                          | ((m_mem == 0) ? 4 : 0) | ((opnd[3:0] == 4'h0) ? 2 : 0) | ((opnd == 0) ? 1 : 0);
                end
                default: begin
                    if (i % 3 == 0) w = 16'h0000;
                    else if (i % 3 == 1) w = {4'hf, rng[11:0]};
                    else w = {4'h1, rng[11:0]};
                end
            endcase
            run_instr(w);
            check_state();
        end
        complete_run();
    end
endmodule
